//--- design/scs_mem.sv
`timescale 1ns/1ps
module scs_mem
#(
    parameter int W     = 8,
    parameter int DEPTH = 16,
    parameter int AW    = 4
)
(
    // Clock.
    input  wire logic          ref_clk_i,
    // Write port.
    input  wire logic          wr_en_i,
    input  wire logic [AW-1:0] wr_addr_i,
    input  wire logic [W-1:0]  wr_data_i,
    // Read port, one cycle latency.
    input  wire logic [AW-1:0] rd_addr_i,
    output logic      [W-1:0]  rd_data_o
);

    logic [W-1:0] mem [DEPTH];

    // Contents need no reset; no slot's data is used before it is written.
    always_ff @(posedge ref_clk_i)
    begin
        if (wr_en_i)
        begin
            mem[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem[rd_addr_i];
    end

endmodule

//--- design/scs_pkg.sv
package scs_pkg;

    localparam int PC_W        = 16;
    localparam int NUM_W       = 7;
    localparam int BIT_W       = 12;
    localparam int DEPTH_W     = 5;
    localparam int STACK_AW    = 4;
    localparam int STACK_DEPTH = 16;
    localparam int TBL_AW      = 7;
    localparam int TBL_DEPTH   = 100;
    localparam int TBL_SLOTS   = 128;

    localparam logic [PC_W-1:0]    PROG_START   = 16'h0000;
    localparam logic [PC_W-1:0]    PROG_LAST    = 16'hFFFF;
    localparam logic [PC_W-1:0]    PC_STEP      = 16'h0001;
    localparam logic [NUM_W-1:0]   SUB_MAX      = 7'h63;
    localparam logic [NUM_W-1:0]   IRQ_SUB_LAST = 7'h1F;
    localparam logic [NUM_W-1:0]   SCHED_SUB    = 7'h63;
    localparam logic [NUM_W-1:0]   SUB_RESET    = 7'h00;
    localparam logic [DEPTH_W-1:0] NEST_MAX     = 5'h10;
    localparam logic [DEPTH_W-1:0] DEPTH_STEP   = 5'h01;
    localparam logic [DEPTH_W-1:0] DEPTH_RESET  = 5'h00;

    typedef enum logic [2:0] {
        SCS_OP_OTHER,
        SCS_OP_DEFINE,
        SCS_OP_EXIT,
        SCS_OP_CALL,
        SCS_OP_END,
        SCS_OP_PULSE
    } scs_op_e;

    typedef enum logic [2:0] {
        SCS_FLT_NONE,
        SCS_FLT_MISSING,
        SCS_FLT_SELF,
        SCS_FLT_NEST,
        SCS_FLT_OPERAND,
        SCS_FLT_DUPLICATE
    } scs_fault_e;

    typedef enum logic [2:0] {
        SCS_ST_SCAN_F,
        SCS_ST_SCAN_E,
        SCS_ST_FETCH,
        SCS_ST_EXEC,
        SCS_ST_LOOKUP,
        SCS_ST_POP
    } scs_state_e;

    typedef struct packed {
        scs_op_e          op;
        logic [NUM_W-1:0] num;
        logic             cond;
        logic             prev;
        logic [BIT_W-1:0] bit_addr;
    } scs_instr_s;

    typedef struct packed {
        logic [PC_W-1:0]  ret_pc;
        logic [NUM_W-1:0] sub;
        logic             in_sub;
    } scs_frame_s;

    typedef struct packed {
        logic             we;
        logic [BIT_W-1:0] addr;
        logic             val;
    } scs_pulse_s;

    localparam int FRAME_W = $bits(scs_frame_s);

endpackage

//--- design/scs_seq.sv
// What this block does
// - Define marker carries number, exit marker none.
// - Stop at first define, restart at zero.
// - Subroutine bodies run only by call or interrupt.
// - Define met in main program restarts program.
// - Subroutine pulse output holds until next run.
// - Markers leave the fault flag unchanged when executed.
// - Call acts only while its condition is on.
// - Call runs from matching define to exit.
// - Return resumes right after the calling instruction.
// - One subroutine may be called from anywhere.
// - Calls inside subroutines nest and return inward.
// - Up to sixteen nested levels are supported.
// - Subroutines 00 to 31 also start by interrupt.
// - Subroutine 99 also serves the scheduled interrupt.
// - Fault when called number has no definition.
// - Fault when a subroutine calls itself.
// - Fault when nesting would exceed sixteen levels.
// - No call is made while fault is on.
// - Numbers are 00 to 99, defined once.
`timescale 1ns/1ps
module scs_seq
(
    // Clock and reset.
    input  wire logic                      ref_clk_i,
    input  wire logic                      reset_i,
    // Instruction fetch path.
    output logic                           fetch_en_o,
    output logic [scs_pkg::PC_W-1:0]       fetch_addr_o,
    input  wire scs_pkg::scs_instr_s       instr_i,
    // Interrupt activation.
    input  wire logic                      irq_valid_i,
    input  wire logic [scs_pkg::NUM_W-1:0] irq_num_i,
    output logic                           irq_ack_o,
    // Fault flag.
    input  wire logic                      fault_clr_i,
    output logic                           fault_o,
    output scs_pkg::scs_fault_e            fault_cause_o,
    // Sequencer status.
    output logic                           ready_o,
    output logic                           cycle_start_o,
    output logic                           in_sub_o,
    output logic [scs_pkg::NUM_W-1:0]      cur_sub_o,
    output logic [scs_pkg::DEPTH_W-1:0]    depth_o,
    // Leading edge pulse output write.
    output scs_pkg::scs_pulse_s            pulse_o
);

    function automatic logic sub_num_ok(input logic [6:0] num);
        sub_num_ok = (num <= scs_pkg::SUB_MAX);
    endfunction

    function automatic logic irq_num_ok(input logic [6:0] num);
        irq_num_ok = (num <= scs_pkg::IRQ_SUB_LAST)
                   || (num == scs_pkg::SCHED_SUB);
    endfunction

    scs_pkg::scs_state_e             state;
    scs_pkg::scs_state_e             next_state;
    logic [scs_pkg::PC_W-1:0]        pc;
    logic [scs_pkg::PC_W-1:0]        next_pc;
    logic [scs_pkg::PC_W-1:0]        ret_pc;
    logic [scs_pkg::PC_W-1:0]        next_ret_pc;
    logic [scs_pkg::NUM_W-1:0]       call_num;
    logic [scs_pkg::NUM_W-1:0]       next_call_num;
    logic [scs_pkg::NUM_W-1:0]       cur_sub;
    logic [scs_pkg::NUM_W-1:0]       next_cur_sub;
    logic                            in_sub;
    logic                            next_in_sub;
    logic [scs_pkg::DEPTH_W-1:0]     depth;
    logic [scs_pkg::DEPTH_W-1:0]     next_depth;
    logic [scs_pkg::DEPTH_W-1:0]     depth_dec;
    logic [scs_pkg::TBL_SLOTS-1:0]   defined;
    logic [scs_pkg::TBL_SLOTS-1:0]   next_defined;
    logic                            fault;
    logic                            next_fault;
    scs_pkg::scs_fault_e             cause;
    scs_pkg::scs_fault_e             next_cause;
    logic                            ready;
    logic                            next_ready;
    logic                            cycle_start;
    logic                            next_cycle_start;
    scs_pkg::scs_pulse_s             pulse;
    scs_pkg::scs_pulse_s             next_pulse;

    logic                            tbl_we;
    logic [scs_pkg::TBL_AW-1:0]      tbl_waddr;
    logic [scs_pkg::TBL_AW-1:0]      tbl_raddr;
    logic [scs_pkg::PC_W-1:0]        tbl_rdata;
    logic                            stk_we;
    logic [scs_pkg::STACK_AW-1:0]    stk_waddr;
    logic [scs_pkg::STACK_AW-1:0]    stk_raddr;
    scs_pkg::scs_frame_s             stk_wdata;
    scs_pkg::scs_frame_s             stk_rdata;

    assign depth_dec = depth - scs_pkg::DEPTH_STEP;

    // Start address of each defined subroutine, indexed by its number.
    scs_mem
    #(
        .W     (scs_pkg::PC_W),
        .DEPTH (scs_pkg::TBL_DEPTH),
        .AW    (scs_pkg::TBL_AW)
    )
    u_def_table
    (
        .ref_clk_i (ref_clk_i),
        .wr_en_i   (tbl_we),
        .wr_addr_i (tbl_waddr),
        .wr_data_i (pc),
        .rd_addr_i (tbl_raddr),
        .rd_data_o (tbl_rdata)
    );

    // Return stack of caller frames.
    scs_mem
    #(
        .W     (scs_pkg::FRAME_W),
        .DEPTH (scs_pkg::STACK_DEPTH),
        .AW    (scs_pkg::STACK_AW)
    )
    u_ret_stack
    (
        .ref_clk_i (ref_clk_i),
        .wr_en_i   (stk_we),
        .wr_addr_i (stk_waddr),
        .wr_data_i (stk_wdata),
        .rd_addr_i (stk_raddr),
        .rd_data_o (stk_rdata)
    );

    always_comb
    begin
        next_state       = state;
        next_pc          = pc;
        next_ret_pc      = ret_pc;
        next_call_num    = call_num;
        next_cur_sub     = cur_sub;
        next_in_sub      = in_sub;
        next_depth       = depth;
        next_defined     = defined;
        next_ready       = ready;
        next_cycle_start = 1'b0;
        next_pulse       = '0;
        next_cause       = cause;
        // A fault raised in the clearing cycle survives the clear.
        next_fault       = fault & ~fault_clr_i;
        tbl_we           = 1'b0;
        tbl_waddr        = instr_i.num;
        tbl_raddr        = instr_i.num;
        stk_we           = 1'b0;
        stk_waddr        = depth[scs_pkg::STACK_AW-1:0];
        stk_raddr        = depth_dec[scs_pkg::STACK_AW-1:0];
        stk_wdata.ret_pc = ret_pc;
        stk_wdata.sub    = cur_sub;
        stk_wdata.in_sub = in_sub;
        irq_ack_o        = 1'b0;
        fetch_en_o       = 1'b0;
        case (state)
            // Discovery pass: learn where each subroutine starts.
            scs_pkg::SCS_ST_SCAN_F:
            begin
                fetch_en_o = 1'b1;
                next_state = scs_pkg::SCS_ST_SCAN_E;
            end
            scs_pkg::SCS_ST_SCAN_E:
            begin
                if (instr_i.op == scs_pkg::SCS_OP_DEFINE)
                begin
                    if (!sub_num_ok(instr_i.num))
                    begin
                        next_fault = 1'b1;
                        next_cause = scs_pkg::SCS_FLT_OPERAND;
                    end
                    else if (defined[instr_i.num])
                    begin
                        next_fault = 1'b1;
                        next_cause = scs_pkg::SCS_FLT_DUPLICATE;
                    end
                    else
                    begin
                        tbl_we                   = 1'b1;
                        next_defined[instr_i.num] = 1'b1;
                    end
                end
                // The terminator follows the last exit marker.
                if ((instr_i.op == scs_pkg::SCS_OP_END)
                    || (pc == scs_pkg::PROG_LAST))
                begin
                    next_pc          = scs_pkg::PROG_START;
                    next_ready       = 1'b1;
                    next_cycle_start = 1'b1;
                    next_state       = scs_pkg::SCS_ST_FETCH;
                end
                else
                begin
                    next_pc    = pc + scs_pkg::PC_STEP;
                    next_state = scs_pkg::SCS_ST_SCAN_F;
                end
            end
            // Interrupts enter only at an instruction boundary.
            scs_pkg::SCS_ST_FETCH:
            begin
                fetch_en_o = 1'b1;
                next_state = scs_pkg::SCS_ST_EXEC;
                irq_ack_o  = irq_valid_i;
                tbl_raddr  = irq_num_i;
                if (irq_valid_i && irq_num_ok(irq_num_i)
                    && defined[irq_num_i]
                    && (depth != scs_pkg::NEST_MAX)
                    && !(in_sub && (irq_num_i == cur_sub)))
                begin
                    // The fetched instruction is dropped and rerun later.
                    next_ret_pc   = pc;
                    next_call_num = irq_num_i;
                    next_state    = scs_pkg::SCS_ST_LOOKUP;
                end
            end
            scs_pkg::SCS_ST_EXEC:
            begin
                next_pc    = pc + scs_pkg::PC_STEP;
                next_state = scs_pkg::SCS_ST_FETCH;
                case (instr_i.op)
                    scs_pkg::SCS_OP_DEFINE:
                    begin
                        // Main program ends here; fault is untouched.
                        if (!in_sub)
                        begin
                            next_pc          = scs_pkg::PROG_START;
                            next_cycle_start = 1'b1;
                        end
                    end
                    scs_pkg::SCS_OP_EXIT:
                    begin
                        if (in_sub)
                        begin
                            next_state = scs_pkg::SCS_ST_POP;
                        end
                    end
                    scs_pkg::SCS_OP_END:
                    begin
                        if (!in_sub)
                        begin
                            next_pc          = scs_pkg::PROG_START;
                            next_cycle_start = 1'b1;
                        end
                    end
                    scs_pkg::SCS_OP_PULSE:
                    begin
                        // Written only when executed, so a pulse in a
                        // subroutine stays on until its next call.
                        next_pulse.we   = 1'b1;
                        next_pulse.addr = instr_i.bit_addr;
                        next_pulse.val  = instr_i.cond & ~instr_i.prev;
                    end
                    scs_pkg::SCS_OP_CALL:
                    begin
                        if (!instr_i.cond || fault)
                        begin
                            next_state = scs_pkg::SCS_ST_FETCH;
                        end
                        else if (!sub_num_ok(instr_i.num))
                        begin
                            next_fault = 1'b1;
                            next_cause = scs_pkg::SCS_FLT_OPERAND;
                        end
                        else if (!defined[instr_i.num])
                        begin
                            next_fault = 1'b1;
                            next_cause = scs_pkg::SCS_FLT_MISSING;
                        end
                        else if (in_sub && (instr_i.num == cur_sub))
                        begin
                            next_fault = 1'b1;
                            next_cause = scs_pkg::SCS_FLT_SELF;
                        end
                        else if (depth == scs_pkg::NEST_MAX)
                        begin
                            next_fault = 1'b1;
                            next_cause = scs_pkg::SCS_FLT_NEST;
                        end
                        else
                        begin
                            // Any call site may name any number.
                            next_ret_pc   = pc + scs_pkg::PC_STEP;
                            next_call_num = instr_i.num;
                            next_state    = scs_pkg::SCS_ST_LOOKUP;
                        end
                    end
                    default:
                    begin
                        next_state = scs_pkg::SCS_ST_FETCH;
                    end
                endcase
            end
            // Table data is ready; push the caller and enter the body.
            scs_pkg::SCS_ST_LOOKUP:
            begin
                stk_we       = 1'b1;
                next_pc      = tbl_rdata + scs_pkg::PC_STEP;
                next_depth   = depth + scs_pkg::DEPTH_STEP;
                next_cur_sub = call_num;
                next_in_sub  = 1'b1;
                next_state   = scs_pkg::SCS_ST_FETCH;
            end
            // Frame is ready; resume in the caller.
            scs_pkg::SCS_ST_POP:
            begin
                next_pc      = stk_rdata.ret_pc;
                next_cur_sub = stk_rdata.sub;
                next_in_sub  = stk_rdata.in_sub;
                next_depth   = depth_dec;
                next_state   = scs_pkg::SCS_ST_FETCH;
            end
            default:
            begin
                next_state = scs_pkg::SCS_ST_SCAN_F;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            state       <= scs_pkg::SCS_ST_SCAN_F;
            pc          <= scs_pkg::PROG_START;
            ret_pc      <= scs_pkg::PROG_START;
            call_num    <= scs_pkg::SUB_RESET;
            cur_sub     <= scs_pkg::SUB_RESET;
            in_sub      <= 1'b0;
            depth       <= scs_pkg::DEPTH_RESET;
            defined     <= '0;
            fault       <= 1'b0;
            cause       <= scs_pkg::SCS_FLT_NONE;
            ready       <= 1'b0;
            cycle_start <= 1'b0;
            pulse       <= '0;
        end
        else
        begin
            state       <= next_state;
            pc          <= next_pc;
            ret_pc      <= next_ret_pc;
            call_num    <= next_call_num;
            cur_sub     <= next_cur_sub;
            in_sub      <= next_in_sub;
            depth       <= next_depth;
            defined     <= next_defined;
            fault       <= next_fault;
            cause       <= next_cause;
            ready       <= next_ready;
            cycle_start <= next_cycle_start;
            pulse       <= next_pulse;
        end
    end

    assign fetch_addr_o  = pc;
    assign fault_o       = fault;
    assign fault_cause_o = cause;
    assign ready_o       = ready;
    assign cycle_start_o = cycle_start;
    assign in_sub_o      = in_sub;
    assign cur_sub_o     = cur_sub;
    assign depth_o       = depth;
    assign pulse_o       = pulse;

endmodule

//--- testbench/scs_prog.sv
`timescale 1ns/1ps
module scs_prog
(
    // Clock.
    input  wire logic                     ref_clk_i,
    // Fetch request.
    input  wire logic                     fetch_en_i,
    input  wire logic [scs_pkg::PC_W-1:0] fetch_addr_i,
    // Word, one cycle after the request.
    output scs_pkg::scs_instr_s           instr_o
);
    scs_pkg::scs_instr_s mem [64];

    // Outside a fetch the word is scrambled, so a stale value cannot pass.
    always @(posedge ref_clk_i)
    begin
        if (fetch_en_i)
            instr_o <= mem[fetch_addr_i[5:0]];
        else
            instr_o <= ~instr_o;
    end
endmodule

//--- testbench/scs_seq_chk.sv
`timescale 1ns/1ps
module scs_seq_chk
(
    // Clock and reset.
    input wire logic                       ref_clk_i,
    input wire logic                       reset_i,
    // Fetch path and interrupt.
    input wire logic                       fetch_en_o,
    input wire logic [scs_pkg::PC_W-1:0]   fetch_addr_o,
    input wire logic                       irq_valid_i,
    input wire logic                       irq_ack_o,
    // Fault and status.
    input wire logic                       fault_clr_i,
    input wire logic                       fault_o,
    input wire logic                       ready_o,
    input wire logic                       cycle_start_o,
    input wire logic                       in_sub_o,
    input wire logic [scs_pkg::DEPTH_W-1:0] depth_o,
    input wire scs_pkg::scs_pulse_s        pulse_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    sequence s_depth_up;
        depth_o == $past(depth_o) + scs_pkg::DEPTH_STEP;
    endsequence

    sequence s_depth_down;
        depth_o == $past(depth_o) - scs_pkg::DEPTH_STEP;
    endsequence

    a_fetch_exec_alt: assert property (fetch_en_o |=> !fetch_en_o)
        else $error("fetch in two cycles in a row");
    a_addr_stands: assert property (
        fetch_en_o |=> $stable(fetch_addr_o))
        else $error("fetch address moved before execute");
    a_irq_ack_fetch: assert property (
        irq_ack_o |-> fetch_en_o && irq_valid_i && ready_o)
        else $error("interrupt acknowledged outside a fetch");
    a_pulse_single: assert property (pulse_o.we |=> !pulse_o.we)
        else $error("pulse write longer than one cycle");
    a_nest_bound: assert property (depth_o <= scs_pkg::NEST_MAX)
        else $error("nesting depth beyond limit");
    a_depth_step: assert property (
        $changed(depth_o) |-> s_depth_up or s_depth_down)
        else $error("depth jumped by more than one");
    a_push_fetch: assert property (
        s_depth_up |-> fetch_en_o && in_sub_o)
        else $error("push not followed by body fetch");
    a_sub_depth: assert property (
        in_sub_o == (depth_o != scs_pkg::DEPTH_RESET))
        else $error("subroutine flag disagrees with depth");
    a_fault_sticky: assert property (
        fault_o && !fault_clr_i |=> fault_o)
        else $error("fault dropped without clear");
    a_fault_no_push: assert property (
        $rose(fault_o) |-> $stable(depth_o))
        else $error("faulting call changed depth");
    a_restart_zero: assert property (
        cycle_start_o |-> fetch_addr_o == scs_pkg::PROG_START && !in_sub_o)
        else $error("restart not at program start");
endmodule

bind scs_seq scs_seq_chk i_scs_seq_chk
(
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .fetch_en_o(fetch_en_o),
    .fetch_addr_o(fetch_addr_o), .irq_valid_i(irq_valid_i),
    .irq_ack_o(irq_ack_o), .fault_clr_i(fault_clr_i), .fault_o(fault_o),
    .ready_o(ready_o), .cycle_start_o(cycle_start_o), .in_sub_o(in_sub_o),
    .depth_o(depth_o), .pulse_o(pulse_o)
);

//--- testbench/scs_seq_test.sv
`timescale 1ns/1ps
module scs_seq_test;
    logic                ref_clk, reset, fetch_en, irq_valid, irq_ack;
    logic                fault_clr, fault, ready, cycle_start, in_sub;
    logic [15:0]         fetch_addr;
    logic [6:0]          irq_num, cur_sub;
    logic [4:0]          depth;
    scs_pkg::scs_instr_s instr;
    scs_pkg::scs_fault_e fault_cause;
    scs_pkg::scs_pulse_s pulse, pulse_last;
    int                  failures, num_checks, max_depth;
    logic                pulse_seen;
    logic [15:0]         trace [$];
    logic [4:0]          dtrace [$];

    scs_seq i_scs_seq (.ref_clk_i(ref_clk), .reset_i(reset),
        .fetch_en_o(fetch_en), .fetch_addr_o(fetch_addr), .instr_i(instr),
        .irq_valid_i(irq_valid), .irq_num_i(irq_num), .irq_ack_o(irq_ack),
        .fault_clr_i(fault_clr), .fault_o(fault), .fault_cause_o(fault_cause),
        .ready_o(ready), .cycle_start_o(cycle_start), .in_sub_o(in_sub),
        .cur_sub_o(cur_sub), .depth_o(depth), .pulse_o(pulse));
    scs_prog i_scs_prog (.ref_clk_i(ref_clk), .fetch_en_i(fetch_en),
        .fetch_addr_i(fetch_addr), .instr_o(instr));

    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk)
    begin
        if (!reset && ready && fetch_en)
        begin
            trace.push_back(fetch_addr);
            dtrace.push_back(depth);
        end
        if (depth > max_depth)
            max_depth = depth;
        if (pulse.we === 1'b1)
        begin
            pulse_seen = 1'b1;
            pulse_last = pulse;
        end
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("unexpected %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task conclude;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task put(input int a, input scs_pkg::scs_op_e op, input int n,
             input logic c);
        i_scs_prog.mem[a] = '{op: op, num: 7'(n), cond: c, prev: 1'b0,
                              bit_addr: 12'h012};
    endtask

    task clear_prog;
        for (int i = 0; i < 64; i++)
            put(i, scs_pkg::SCS_OP_OTHER, 0, 1'b0);
    endtask

    // The discovery pass reads the program right after reset, so load it before this.
    task boot;
        int i;
        reset <= 1'b1;
        repeat (8) @(posedge ref_clk);
        reset <= 1'b0;
        trace.delete();
        dtrace.delete();
        max_depth = 0;
        pulse_seen = 1'b0;
        i = 0;
        @(posedge ref_clk);
        while (ready !== 1'b1 && i < 2000)
        begin
            @(posedge ref_clk);
            i++;
        end
        check(ready, 1'b1);
    endtask

    task expect_trace(input int ea[], input int ed[]);
        check(trace.size() >= ea.size(), 1'b1);
        foreach (ea[i])
        begin
            check(trace[i], ea[i]);
            check(dtrace[i], ed[i]);
        end
    endtask

    task test_call_return;
        clear_prog;
        put(0, scs_pkg::SCS_OP_CALL, 5, 1'b1);
        put(1, scs_pkg::SCS_OP_CALL, 5, 1'b0);
        put(2, scs_pkg::SCS_OP_CALL, 5, 1'b1);
        put(3, scs_pkg::SCS_OP_DEFINE, 5, 1'b0);
        put(4, scs_pkg::SCS_OP_PULSE, 0, 1'b1);
        put(5, scs_pkg::SCS_OP_CALL, 6, 1'b1);
        put(6, scs_pkg::SCS_OP_EXIT, 0, 1'b0);
        put(7, scs_pkg::SCS_OP_DEFINE, 6, 1'b0);
        put(8, scs_pkg::SCS_OP_EXIT, 0, 1'b0);
        put(9, scs_pkg::SCS_OP_END, 0, 1'b0);
        boot;
        repeat (60) @(posedge ref_clk);
        expect_trace('{0, 4, 5, 8, 6, 1, 2, 4, 5, 8, 6, 3, 0},
                     '{0, 1, 1, 2, 1, 0, 0, 1, 1, 2, 1, 0, 0});
        check({pulse_seen, pulse_last.val}, 2'h3);
        check(pulse_last.addr, 12'h012);
        check(fault, 1'b0);
        $display("test call_return done");
    endtask

    task test_faults;
        logic low;
        clear_prog;
        put(0, scs_pkg::SCS_OP_CALL, 7, 1'b1);
        put(1, scs_pkg::SCS_OP_DEFINE, 5, 1'b0);
        put(2, scs_pkg::SCS_OP_EXIT, 0, 1'b0);
        put(3, scs_pkg::SCS_OP_END, 0, 1'b0);
        boot;
        repeat (30) @(posedge ref_clk);
        expect_trace('{0, 1, 0, 1}, '{0, 0, 0, 0});
        check({fault, fault_cause}, {1'b1, scs_pkg::SCS_FLT_MISSING});
        fault_clr <= 1'b1;
        @(posedge ref_clk);
        fault_clr <= 1'b0;
        low = 1'b0;
        repeat (3)
        begin
            @(posedge ref_clk);
            low = low | (fault === 1'b0);
        end
        check(low, 1'b1);
        // The self call below is planted on purpose to provoke the fault.
        clear_prog;
        put(0, scs_pkg::SCS_OP_CALL, 5, 1'b1);
        put(1, scs_pkg::SCS_OP_DEFINE, 5, 1'b0);
        put(2, scs_pkg::SCS_OP_CALL, 5, 1'b1);
        put(3, scs_pkg::SCS_OP_EXIT, 0, 1'b0);
        put(4, scs_pkg::SCS_OP_END, 0, 1'b0);
        boot;
        repeat (40) @(posedge ref_clk);
        expect_trace('{0, 2, 3, 1, 0, 1, 0}, '{0, 1, 1, 0, 0, 0, 0});
        check({fault, fault_cause}, {1'b1, scs_pkg::SCS_FLT_SELF});
        clear_prog;
        put(0, scs_pkg::SCS_OP_CALL, 0, 1'b1);
        for (int k = 0; k < 18; k++)
        begin
            put(1 + 3 * k, scs_pkg::SCS_OP_DEFINE, k, 1'b0);
            put(2 + 3 * k, scs_pkg::SCS_OP_CALL, k + 1, k < 17);
            put(3 + 3 * k, scs_pkg::SCS_OP_EXIT, 0, 1'b0);
        end
        put(55, scs_pkg::SCS_OP_END, 0, 1'b0);
        boot;
        repeat (200) @(posedge ref_clk);
        check(max_depth, 16);
        check({fault, fault_cause}, {1'b1, scs_pkg::SCS_FLT_NEST});
        put(0, scs_pkg::SCS_OP_DEFINE, 3, 1'b0);
        put(1, scs_pkg::SCS_OP_DEFINE, 3, 1'b0);
        put(2, scs_pkg::SCS_OP_END, 0, 1'b0);
        boot;
        check({fault, fault_cause}, {1'b1, scs_pkg::SCS_FLT_DUPLICATE});
        $display("test faults done");
    endtask

    task test_interrupts;
        int   nums [4];
        logic want [4];
        logic seen;
        int   i;
        nums = '{0, 31, 99, 32};
        want = '{1'b1, 1'b1, 1'b1, 1'b0};
        clear_prog;
        put(2, scs_pkg::SCS_OP_DEFINE, 0, 1'b0);
        put(3, scs_pkg::SCS_OP_EXIT, 0, 1'b0);
        put(4, scs_pkg::SCS_OP_DEFINE, 31, 1'b0);
        put(5, scs_pkg::SCS_OP_EXIT, 0, 1'b0);
        put(6, scs_pkg::SCS_OP_DEFINE, 99, 1'b0);
        put(7, scs_pkg::SCS_OP_EXIT, 0, 1'b0);
        put(8, scs_pkg::SCS_OP_DEFINE, 32, 1'b0);
        put(9, scs_pkg::SCS_OP_EXIT, 0, 1'b0);
        put(10, scs_pkg::SCS_OP_END, 0, 1'b0);
        boot;
        foreach (nums[j])
        begin
            irq_num <= 7'(nums[j]);
            irq_valid <= 1'b1;
            i = 0;
            @(posedge ref_clk);
            while (irq_ack !== 1'b1 && i < 50)
            begin
                @(posedge ref_clk);
                i++;
            end
            irq_valid <= 1'b0;
            check(irq_ack, 1'b1);
            seen = 1'b0;
            repeat (10)
            begin
                @(posedge ref_clk);
                seen = seen | (in_sub === 1'b1 && cur_sub === 7'(nums[j]));
            end
            check(seen, want[j]);
        end
        $display("test interrupts done");
    endtask

    initial
    begin
        reset = 1'b1;
        irq_valid = 1'b0;
        irq_num = 7'h00;
        fault_clr = 1'b0;
        failures = 0;
        num_checks = 0;
        test_call_return;
        test_faults;
        test_interrupts;
        conclude;
    end

    // Every test together needs well under two thousand cycles.
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        conclude;
    end
endmodule
